// [logic/ecb_fir_tap_coefficient_bank.sv]
// wishbone register bank for equalizer_filter taps six to nine and channel b tap one
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - low twelve bits hold signed two's complement coefficient
// - bits 15:12 reserved, read/write, reset zero
// - first channel a register drives tap six
// - register 0x425 drives tap seven
// - register 0x427 drives tap eight
// - register 0x429 drives tap nine, the last
// - all coefficient registers reset to zero
// - channel b tap one at 0x448, same layout
// - channel b taps apply only in dual mode
// - nine taps; centre eighteen bits, others twelve
module ecb_fir_tap_coefficient_bank (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [12:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic signed [11:0] tap6_coef_o,
    output logic signed [11:0] tap7_coef_o,
    output logic signed [11:0] tap8_coef_o,
    output logic signed [11:0] tap9_coef_o,
    output logic signed [11:0] chan_b_tap1_coef_o,
    output logic dual_mode_o
);
    // ****************************************
    // declarations
    // ****************************************
    logic ack_q;                    // single-cycle answer flag
    logic [31:0] rdat_q;            // registered read data
    logic dual_q;                   // dual channel mode
    logic [11:0] b_tap1_q;          // gated channel b coefficient
    logic [10:0] idx;               // word index of the access
    logic [2:0] slot;               // decoded coefficient slot
    logic req;                      // new request, not yet answered
    logic wr_fire;                  // write commits at the answering edge
    logic [15:0] coef_q [ecb_pkg::NUM_COEF]; // coefficient registers
    logic [ecb_pkg::NUM_COEF-1:0] wr_en;     // per-register write strobes

    // ****************************************
    // decode helpers
    // ****************************************
    // index to slot, shared by read mux and write strobes
    function automatic logic [2:0] slot_of(input logic [10:0] i);
        logic [2:0] s;
        s = ecb_pkg::SLOT_NONE;
        case (i)
            ecb_pkg::IDX_A_TAP6: s = ecb_pkg::SLOT_A_TAP6;
            ecb_pkg::IDX_A_TAP7: s = ecb_pkg::SLOT_A_TAP7;
            ecb_pkg::IDX_A_TAP8: s = ecb_pkg::SLOT_A_TAP8;
            ecb_pkg::IDX_A_TAP9: s = ecb_pkg::SLOT_A_TAP9;
            ecb_pkg::IDX_B_TAP1: s = ecb_pkg::SLOT_B_TAP1;
            default: s = ecb_pkg::SLOT_NONE;
        endcase
        return s;
    endfunction : slot_of

    // indices count words, so each one sits at four times its value
    assign idx = wb_adr_i[12:2];
    assign slot = slot_of(idx);
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    // write lands on the edge where the master sees ack, never earlier
    assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;

    // ****************************************
    // bus handshake
    // ****************************************
    // answer one cycle after the request, then drop for a cycle
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end
    assign wb_ack_o = ack_q;

    // read mux, captured at the request edge; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdat_q <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            if (slot != ecb_pkg::SLOT_NONE) begin
                rdat_q <= {16'h0000, coef_q[slot]};
            end else if (idx == ecb_pkg::IDX_CTRL) begin
                rdat_q <= {30'h0000_0000, dual_q, dual_q};
            end else begin
                rdat_q <= 32'h0000_0000;
            end
        end
    end
    assign wb_dat_o = rdat_q;

    // ****************************************
    // coefficient storage
    // ****************************************
    // one register per slot; reserved bits stored like the rest
    for (genvar k = 0; k < ecb_pkg::NUM_COEF; k++) begin : g_coef
        assign wr_en[k] = wr_fire && (slot == 3'(k));
        ecb_coef_reg u_reg (
            .clk_i(clk_i),
            .rstn_i(rstn_i),
            .wr_en_i(wr_en[k]),
            .sel_i(wb_sel_i[1:0]),
            .wdat_i(wb_dat_i[15:0]),
            .q_o(coef_q[k])
        );
    end

    // ****************************************
    // mode control
    // ****************************************
    // mode bit written through lane zero of the control word
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            dual_q <= ecb_pkg::CTRL_DUAL_RST;
        end else if (wr_fire && idx == ecb_pkg::IDX_CTRL && wb_sel_i[0]) begin
            dual_q <= wb_dat_i[ecb_pkg::CTRL_DUAL_BIT];
        end
    end
    assign dual_mode_o = dual_q;

    // ****************************************
    // coefficients towards the filter
    // ****************************************
    // shared filter in single mode and channel a in dual mode use the same taps
    // only the 12-bit outer taps live here; the wide centre tap is elsewhere
    assign tap6_coef_o = $signed(coef_q[ecb_pkg::SLOT_A_TAP6][11:0]);
    assign tap7_coef_o = $signed(coef_q[ecb_pkg::SLOT_A_TAP7][11:0]);
    assign tap8_coef_o = $signed(coef_q[ecb_pkg::SLOT_A_TAP8][11:0]);
    assign tap9_coef_o = $signed(coef_q[ecb_pkg::SLOT_A_TAP9][11:0]);

    // channel b filter sees zero in single mode, so it adds nothing
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            b_tap1_q <= 12'h000;
        end else if (dual_q) begin
            b_tap1_q <= coef_q[ecb_pkg::SLOT_B_TAP1][11:0];
        end else begin
            b_tap1_q <= 12'h000;
        end
    end
    assign chan_b_tap1_coef_o = $signed(b_tap1_q);

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    // a full write of one register to its index
    sequence wr_full(logic [10:0] i);
        wb_cyc_i && wb_stb_i && wb_we_i && ack_q && idx == i && wb_sel_i[1:0] == 2'h3;
    endsequence

    bus_ack_once_a: assert property (
        req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle pulse");

    tap6_follows_a: assert property (
        wr_full(ecb_pkg::IDX_A_TAP6) |=> tap6_coef_o == $past(wb_dat_i[11:0]))
        else $error("tap six not updated by its register");

    tap7_follows_a: assert property (
        wr_full(ecb_pkg::IDX_A_TAP7) |=> tap7_coef_o == $past(wb_dat_i[11:0]))
        else $error("tap seven not updated by its register");

    tap8_follows_a: assert property (
        wr_full(ecb_pkg::IDX_A_TAP8) |=> tap8_coef_o == $past(wb_dat_i[11:0]))
        else $error("tap eight not updated by its register");

    tap9_follows_a: assert property (
        wr_full(ecb_pkg::IDX_A_TAP9) |=> tap9_coef_o == $past(wb_dat_i[11:0]))
        else $error("tap nine not updated by its register");

    rsvd_bits_kept_a: assert property (
        wr_full(ecb_pkg::IDX_A_TAP6)
        |=> coef_q[ecb_pkg::SLOT_A_TAP6][15:12] == $past(wb_dat_i[15:12]))
        else $error("reserved bits not stored");

    reset_zero_a: assert property (
        $rose(rstn_i) |-> tap6_coef_o == 12'h000 && tap9_coef_o == 12'h000
            && chan_b_tap1_coef_o == 12'h000 && coef_q[ecb_pkg::SLOT_A_TAP7] == 16'h0000)
        else $error("coefficients not zero after reset");

    chan_b_dual_a: assert property (
        wr_full(ecb_pkg::IDX_B_TAP1) ##1 dual_q [*2]
        |-> chan_b_tap1_coef_o == $past(wb_dat_i[11:0], 2))
        else $error("channel b tap one not delivered in dual mode");

    chan_b_single_a: assert property (
        !dual_q |=> chan_b_tap1_coef_o == 12'h000)
        else $error("channel b tap active in single mode");

    read_back_a: assert property (
        req && !wb_we_i && idx == ecb_pkg::IDX_A_TAP8
        |=> wb_ack_o && wb_dat_o == {16'h0000, $past(coef_q[ecb_pkg::SLOT_A_TAP8])})
        else $error("read back differs from stored value");

    unmapped_zero_a: assert property (
        req && !wb_we_i && slot == ecb_pkg::SLOT_NONE && idx != ecb_pkg::IDX_CTRL
        |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    // ****************************************
    // further bus and storage checks
    // ****************************************
    // a write that is not committed must leave all five registers alone
    sequence no_commit;
        !wr_fire;
    endsequence

    // an answer only ever follows a request taken one edge before
    ack_has_req_a: assert property (
        wb_ack_o |-> $past(req))
        else $error("ack without a taken request");

    // read data stands until the next read is taken
    rdat_stands_a: assert property (
        !(req && !wb_we_i) |=> $stable(wb_dat_o))
        else $error("read data changed without a read");

    // storage is quiet between commits
    coef_quiet_a: assert property (
        no_commit |=> $stable(coef_q[ecb_pkg::SLOT_A_TAP6]) && $stable(coef_q[ecb_pkg::SLOT_A_TAP7])
            && $stable(coef_q[ecb_pkg::SLOT_A_TAP8]) && $stable(coef_q[ecb_pkg::SLOT_A_TAP9])
            && $stable(coef_q[ecb_pkg::SLOT_B_TAP1]))
        else $error("coefficient changed without a write");

    // a hole in the map swallows writes without side effects
    hole_write_a: assert property (
        wr_fire && slot == ecb_pkg::SLOT_NONE
        |=> $stable(coef_q[ecb_pkg::SLOT_A_TAP6]) && $stable(coef_q[ecb_pkg::SLOT_A_TAP7])
            && $stable(coef_q[ecb_pkg::SLOT_B_TAP1]))
        else $error("unmapped write touched a coefficient");

    // lane zero alone keeps the high byte, reserved nibble included
    lane_keep_a: assert property (
        wr_fire && slot == ecb_pkg::SLOT_A_TAP7 && wb_sel_i[1:0] == 2'h1
        |=> coef_q[ecb_pkg::SLOT_A_TAP7][15:8] == $past(coef_q[ecb_pkg::SLOT_A_TAP7][15:8]))
        else $error("unselected lane overwritten");

    // mode bit follows a lane-zero control write
    mode_write_a: assert property (
        wr_fire && idx == ecb_pkg::IDX_CTRL && wb_sel_i[0]
        |=> dual_mode_o == $past(wb_dat_i[ecb_pkg::CTRL_DUAL_BIT]))
        else $error("mode bit not written");

    // control read shows the mode in both bits
    ctrl_read_a: assert property (
        req && !wb_we_i && idx == ecb_pkg::IDX_CTRL
        |=> wb_dat_o == {30'h0000_0000, $past(dual_q), $past(dual_q)})
        else $error("control read wrong");

    // in dual mode channel b trails its register by exactly one edge
    chan_b_track_a: assert property (
        dual_q |=> chan_b_tap1_coef_o == $signed($past(coef_q[ecb_pkg::SLOT_B_TAP1][11:0])))
        else $error("channel b tap one lags wrongly");
endmodule : ecb_fir_tap_coefficient_bank
`default_nettype wire

// [inc/ecb_pkg.sv]
// shared constants of the equalizer filter coefficient bank
package ecb_pkg;
    // ****************************************
    // register layout
    // ****************************************
    localparam int unsigned REG_W = 16;          // width of one coefficient register
    localparam int unsigned COEF_W = 12;         // coefficient field width, outer taps
    localparam int unsigned COEF_MSB = 11;       // top bit of the coefficient field
    localparam int unsigned RSVD_LSB = 12;       // reserved field, low bit
    localparam int unsigned RSVD_MSB = 15;       // reserved field, high bit
    localparam int unsigned CENTRE_COEF_W = 18;  // centre tap width, kept outside this bank
    localparam int unsigned TAP_COUNT = 9;       // taps per equalizer_filter
    localparam int unsigned NUM_COEF = 5;        // coefficient registers held here
    localparam logic [15:0] COEF_RST = 16'h0000; // every coefficient resets to zero

    // ****************************************
    // register indices (byte address = index * 4)
    // ****************************************
    localparam int unsigned ADR_W = 13;          // wishbone byte address width
    localparam int unsigned IDX_W = 11;          // register index width
    localparam logic [10:0] IDX_A_TAP6 = 11'h423;
    localparam logic [10:0] IDX_A_TAP7 = 11'h425;
    localparam logic [10:0] IDX_A_TAP8 = 11'h427;
    localparam logic [10:0] IDX_A_TAP9 = 11'h429;
    localparam logic [10:0] IDX_B_TAP1 = 11'h448;
    localparam logic [10:0] IDX_CTRL = 11'h460;  // mode control and status

    // ****************************************
    // slots of the coefficient array
    // ****************************************
    localparam logic [2:0] SLOT_A_TAP6 = 3'h0;
    localparam logic [2:0] SLOT_A_TAP7 = 3'h1;
    localparam logic [2:0] SLOT_A_TAP8 = 3'h2;
    localparam logic [2:0] SLOT_A_TAP9 = 3'h3;
    localparam logic [2:0] SLOT_B_TAP1 = 3'h4;
    localparam logic [2:0] SLOT_NONE = 3'h7;

    // ****************************************
    // control register fields
    // ****************************************
    localparam int unsigned CTRL_DUAL_BIT = 0;   // 1: dual channel, 0: single channel
    localparam int unsigned CTRL_BACT_BIT = 1;   // read only: channel b taps in use
    localparam logic CTRL_DUAL_RST = 1'b1;
endpackage : ecb_pkg

// [logic/ecb_coef_reg.sv]
// one 16-bit coefficient register with byte-lane writes
`timescale 1ns/1ps
`default_nettype none
module ecb_coef_reg (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic wr_en_i,
    input wire logic [1:0] sel_i,
    input wire logic [15:0] wdat_i,
    output logic [15:0] q_o
);
    // ****************************************
    // storage
    // ****************************************
    logic [15:0] val_q; // coefficient plus reserved field

    // low lane: bits 7:0 of the coefficient
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            val_q[7:0] <= ecb_pkg::COEF_RST[7:0];
        end else if (wr_en_i && sel_i[0]) begin
            val_q[7:0] <= wdat_i[7:0];
        end
    end

    // high lane: coefficient top nibble and reserved bits, both writable
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            val_q[15:8] <= ecb_pkg::COEF_RST[15:8];
        end else if (wr_en_i && sel_i[1]) begin
            val_q[15:8] <= wdat_i[15:8];
        end
    end

    assign q_o = val_q;
endmodule : ecb_coef_reg
`default_nettype wire

// [bench/ecb_fir_tap_coefficient_bank_bench.sv]
// self-checking bench for the equalizer_filter coefficient bank
`timescale 1ns/1ps
`default_nettype none
module ecb_fir_tap_coefficient_bank_bench;
    // ****************************************
    // signals around the block
    // ****************************************
    logic clk_i = 1'b0; // 25 MHz bus clock
    logic rstn_i = 1'b0; // synchronous reset, low active
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [12:0] wb_adr_i = 13'h0000; // byte address
    logic [3:0] wb_sel_i = 4'h0; // byte lanes
    logic [31:0] wb_dat_i = 32'h0000_0000; // write data
    logic [31:0] wb_dat_o; // read data
    logic wb_ack_o; // one-cycle answer
    logic signed [11:0] t6, t7, t8, t9, tb1; // filter-side coefficients
    logic dual_mode_o; // mode seen by the filters
    int fail_count = 0; // mismatches so far
    int num_checks = 0; // comparisons so far
    ecb_fir_tap_coefficient_bank dut (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tap6_coef_o(t6),
        .tap7_coef_o(t7), .tap8_coef_o(t8), .tap9_coef_o(t9), .chan_b_tap1_coef_o(tb1),
        .dual_mode_o(dual_mode_o));
    // free-running clock, 40 ns period
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // ****************************************
    // helpers
    // ****************************************
    // register index to byte address
    function automatic logic [12:0] badr(input logic [10:0] idx);
        return {idx, 2'b00};
    endfunction : badr
    // one compare for every kind of result, widened to a word
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // classic single cycle; request held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [12:0] adr, input logic [3:0] sel,
                           input logic [31:0] dat, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        // look at ack mid-cycle, away from the edge that launches it
        do begin
            @(negedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        // a missing answer is a mismatch, not a hang
        if (n >= 50) chk("ack", 32'h1, 32'h0);
        rd = wb_dat_o;
        // the ack edge: the write lands here, request still standing
        @(posedge clk_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_xfer
    task automatic wr(input logic [10:0] idx, input logic [3:0] sel, input logic [31:0] dat);
        logic [31:0] rd;
        wb_xfer(1'b1, badr(idx), sel, dat, rd);
    endtask : wr
    task automatic rd_chk(input string name, input logic [10:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        wb_xfer(1'b0, badr(idx), 4'hF, 32'h0000_0000, rd);
        chk(name, exp, rd);
    endtask : rd_chk
    // filter side settles at the ack edge, channel b one cycle after it
    task automatic taps_chk(input logic [11:0] e6, e7, e8, e9, eb, input logic ed);
        @(posedge clk_i);
        @(negedge clk_i);
        chk("tap6", {20'h0, e6}, {20'h0, t6});
        chk("tap7", {20'h0, e7}, {20'h0, t7});
        chk("tap8", {20'h0, e8}, {20'h0, t8});
        chk("tap9", {20'h0, e9}, {20'h0, t9});
        chk("b_tap1", {20'h0, eb}, {20'h0, tb1});
        chk("dual", {31'h0, ed}, {31'h0, dual_mode_o});
    endtask : taps_chk
    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_reset();
        rd_chk("a6", ecb_pkg::IDX_A_TAP6, 32'h0000_0000);
        rd_chk("a7", ecb_pkg::IDX_A_TAP7, 32'h0000_0000);
        rd_chk("a8", ecb_pkg::IDX_A_TAP8, 32'h0000_0000);
        rd_chk("a9", ecb_pkg::IDX_A_TAP9, 32'h0000_0000);
        rd_chk("b1", ecb_pkg::IDX_B_TAP1, 32'h0000_0000);
        rd_chk("ctrl", ecb_pkg::IDX_CTRL, 32'h0000_0003);
        taps_chk(12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 1'b1);
    endtask : test_reset
    // every register, reserved nibble set, junk in the upper word
    task automatic test_write_all();
        logic [10:0] idx[5];
        logic [15:0] val[5];
        idx = '{ecb_pkg::IDX_A_TAP6, ecb_pkg::IDX_A_TAP7, ecb_pkg::IDX_A_TAP8,
                ecb_pkg::IDX_A_TAP9, ecb_pkg::IDX_B_TAP1};
        val = '{16'hA123, 16'h5456, 16'hF789, 16'h3ABC, 16'hCDEF};
        for (int i = 0; i < 5; i++) wr(idx[i], 4'h3, {16'h5A5A, val[i]});
        for (int i = 0; i < 5; i++) rd_chk("readback", idx[i], {16'h0, val[i]});
        taps_chk(12'h123, 12'h456, 12'h789, 12'hABC, 12'hDEF, 1'b1);
    endtask : test_write_all
    // single lanes leave the other byte alone
    task automatic test_lanes();
        wr(ecb_pkg::IDX_A_TAP7, 4'h1, 32'hFFFF_EE11);
        rd_chk("lane0", ecb_pkg::IDX_A_TAP7, 32'h0000_5411);
        wr(ecb_pkg::IDX_A_TAP7, 4'h2, 32'hFFFF_22EE);
        rd_chk("lane1", ecb_pkg::IDX_A_TAP7, 32'h0000_2211);
    endtask : test_lanes
    // most negative coefficient must extend its sign
    task automatic test_sign();
        wr(ecb_pkg::IDX_A_TAP9, 4'h3, 32'h0000_0800);
        @(posedge clk_i);
        @(negedge clk_i);
        chk("tap9_signed", 32'hFFFF_F800, 32'($signed(t9)));
    endtask : test_sign
    // single mode blanks channel b only; stored value survives
    task automatic test_mode();
        wr(ecb_pkg::IDX_CTRL, 4'h1, 32'h0000_0002);
        rd_chk("ctrl_single", ecb_pkg::IDX_CTRL, 32'h0000_0000);
        taps_chk(12'h123, 12'h211, 12'h789, 12'h800, 12'h000, 1'b0);
        rd_chk("b1_kept", ecb_pkg::IDX_B_TAP1, 32'h0000_CDEF);
        wr(ecb_pkg::IDX_CTRL, 4'h1, 32'h0000_0001);
        taps_chk(12'h123, 12'h211, 12'h789, 12'h800, 12'hDEF, 1'b1);
    endtask : test_mode
    // hole between two taps: answers, reads zero, touches nothing
    task automatic test_unmapped();
        wr(11'h424, 4'hF, 32'hFFFF_FFFF);
        rd_chk("hole", 11'h424, 32'h0000_0000);
        rd_chk("a6_safe", ecb_pkg::IDX_A_TAP6, 32'h0000_A123);
        rd_chk("a7_safe", ecb_pkg::IDX_A_TAP7, 32'h0000_2211);
    endtask : test_unmapped
    // ****************************************
    // verdict and sequencing
    // ****************************************
    task automatic tally_and_finish();
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    // whole run is under a hundred cycles; this is ample margin
    initial begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        test_reset();
        test_write_all();
        test_lanes();
        test_sign();
        test_mode();
        test_unmapped();
        tally_and_finish();
    end
endmodule : ecb_fir_tap_coefficient_bank_bench
`default_nettype wire
